//--- shared/timer_pkg.sv
package timer_pkg;
	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0] OFF_CTRL0 = 8'h00;
	localparam logic [7:0] OFF_CTRL1 = 8'h04;
	localparam logic [7:0] OFF_CMPA = 8'h08;
	localparam logic [7:0] OFF_COUNT = 8'h0C;
	localparam logic [7:0] OFF_STATUS = 8'h10;
	localparam logic [7:0] OFF_MASK = 8'h14;

	// ****************************************
	// field positions and resets
	// ****************************************
	localparam int CNT_W = 10;
	localparam int PER_W = 3;
	localparam int ON_BIT = 3;
	localparam int MODE_HI = 7;
	localparam int MODE_LO = 6;
	localparam int FUNC_HI = 5;
	localparam int FUNC_LO = 4;
	localparam int LEVEL_BIT = 3;
	localparam int INVERT_BIT = 2;
	localparam int SWAP_BIT = 1;
	localparam int CLRSEL_BIT = 0;
	localparam int FLAG_A = 0;
	localparam int FLAG_P = 1;
	localparam logic [7:0] CTRL0_RST = 8'h00;
	localparam logic [7:0] CTRL1_RST = 8'h00;
	localparam logic [9:0] CMPA_RST = 10'h000;
	localparam logic [1:0] MASK_RST = 2'h0;
	localparam logic [9:0] CNT_MAX = 10'h3FF;

	// ****************************************
	// modes and output functions
	// ****************************************
	typedef enum logic [1:0] {
		MODE_CMP = 2'b00,
		MODE_UNDEF = 2'b01,
		MODE_PWM = 2'b10,
		MODE_TC = 2'b11
	} mode_t;
	localparam logic [1:0] FUNC_NONE = 2'b00;
	localparam logic [1:0] FUNC_LOW = 2'b01;
	localparam logic [1:0] FUNC_HIGH = 2'b10;
	localparam logic [1:0] FUNC_TOGGLE = 2'b11;
	localparam logic [1:0] PWM_FORCE_OFF = 2'b00;
	localparam logic [1:0] PWM_FORCE_ON = 2'b01;
	localparam logic [1:0] PWM_RUN = 2'b10;
endpackage

//--- shared/timer_pin_if.sv
`timescale 1ns/100ps
interface timer_pin_if;
	import timer_pkg::*;
	mode_t mode;
	logic [1:0] out_func;
	logic level_ctl;
	logic invert;
	logic start;
	logic a_event;
	logic duty_active;
	modport ctl (output mode, out_func, level_ctl, invert, start, a_event,
		duty_active);
	modport pin (input mode, out_func, level_ctl, invert, start, a_event,
		duty_active);
endinterface

//--- src/timer_pin_stage.sv
`timescale 1ns/100ps
module timer_pin_stage
	import timer_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	timer_pin_if.pin ctl,
	output logic pin_o,
	output logic oe_o
);
	logic level;
	logic next_level;
	logic next_pin;
	logic next_oe;

	// ****************************************
	// compare state and pin drive
	// ****************************************
	always_comb begin
		next_level = level;
		if (ctl.start) begin
			next_level = ctl.level_ctl;
		end else if (ctl.a_event && ctl.mode == MODE_CMP) begin
			case (ctl.out_func)
				FUNC_LOW: next_level = 1'b0;
				FUNC_HIGH: next_level = 1'b1;
				FUNC_TOGGLE: next_level = ~level;
				default: next_level = level;
			endcase
		end
		next_pin = 1'b0;
		next_oe = 1'b0;
		case (ctl.mode)
			MODE_CMP: begin
				next_oe = 1'b1;
				next_pin = next_level ^ ctl.invert;
			end
			MODE_PWM: begin
				next_oe = 1'b1;
				// forcing the pin leaves the counter untouched
				case (ctl.out_func)
					PWM_FORCE_ON: next_pin = ctl.level_ctl ^ ctl.invert;
					PWM_RUN: next_pin = (ctl.duty_active ? ctl.level_ctl
						: ~ctl.level_ctl) ^ ctl.invert;
					default: next_pin = ~ctl.level_ctl ^ ctl.invert;
				endcase
			end
			default: begin
				// pin left to other functions, polarity irrelevant
				next_oe = 1'b0;
				next_pin = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			level <= 1'b0;
			pin_o <= 1'b0;
			oe_o <= 1'b0;
		end else begin
			level <= next_level;
			pin_o <= next_pin;
			oe_o <= next_oe;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	start_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ctl.start && ctl.mode == MODE_CMP |=>
		pin_o == ($past(ctl.level_ctl) ^ $past(ctl.invert)))
		else $error("pin not set to initial level at start");
	tc_pin_free_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ctl.mode == MODE_TC |=> !oe_o)
		else $error("pin driven in timer/counter mode");
	force_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ctl.mode == MODE_PWM && ctl.out_func == PWM_FORCE_ON |=>
		pin_o == ($past(ctl.level_ctl) ^ $past(ctl.invert)))
		else $error("forced pwm level wrong");
endmodule

//--- src/compact_timer.sv
`timescale 1ns/100ps
module compact_timer
	import timer_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] adr_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	input wire logic we_i,
	input wire logic [3:0] sel_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	output logic ack_o,
	input wire logic count_tick_i,
	output logic irq_o,
	output logic timer_out_pin_a_o,
	output logic timer_out_pin_b_o,
	output logic timer_pin_oe_o
);
	timer_pin_if pif ();

	logic [7:0] ctrl0;
	logic [7:0] timer_control_one;
	logic [CNT_W-1:0] compare_a_value;
	logic [CNT_W-1:0] count;
	logic [1:0] status;
	logic [1:0] mask;
	logic on_q;
	logic [7:0] next_ctrl0;
	logic [7:0] next_ctrl1;
	logic [CNT_W-1:0] next_cmpa;
	logic [CNT_W-1:0] next_count;
	logic [1:0] next_status;
	logic [1:0] next_mask;
	logic [31:0] next_dat;
	logic next_ack;
	logic next_irq;

	logic req;
	logic wr;
	logic counter_on;
	logic start;
	logic running;
	logic [PER_W-1:0] period_compare_value;
	mode_t mode;
	logic is_pwm;
	logic clear_on_a;
	logic [CNT_W:0] inc;
	logic a_hit;
	logic p_hit;
	logic a_event;
	logic p_event;
	logic status_rd;

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [7:0] merge8(input logic [7:0] old,
		input logic [7:0] wd, input logic en);
		merge8 = en ? wd : old;
	endfunction

	function automatic logic at_period(input logic [CNT_W:0] value,
		input logic [PER_W-1:0] per);
		at_period = (per != '0) &&
			(value == {1'b0, per, {(CNT_W-PER_W){1'b0}}});
	endfunction

	// ****************************************
	// decode
	// ****************************************
	assign req = cyc_i && stb_i && !ack_o;
	assign wr = req && we_i;
	assign counter_on = ctrl0[ON_BIT];
	assign period_compare_value = ctrl0[PER_W-1:0];
	assign mode = mode_t'(timer_control_one[MODE_HI:MODE_LO]);
	assign is_pwm = (mode == MODE_PWM);
	assign start = counter_on && !on_q;
	assign running = counter_on && count_tick_i;
	assign status_rd = req && !we_i && adr_i == OFF_STATUS;

	// ****************************************
	// counter and comparators
	// ****************************************
	// pwm takes its clear source from the swap bit instead
	assign clear_on_a = is_pwm ? timer_control_one[SWAP_BIT]
		: timer_control_one[CLRSEL_BIT];
	assign inc = {1'b0, count} + {{CNT_W{1'b0}}, 1'b1};
	// zero compare value never matches, so counter wraps at the top
	assign a_hit = running && compare_a_value != '0 &&
		inc[CNT_W-1:0] == compare_a_value;
	assign p_hit = running && at_period(inc, period_compare_value);
	assign a_event = a_hit;
	assign p_event = p_hit && (is_pwm || !clear_on_a);

	always_comb begin
		next_count = count;
		if (start) begin
			next_count = '0;
		end else if (running) begin
			if (clear_on_a ? a_hit : p_hit) begin
				next_count = '0;
			end else begin
				// top count rolls over to zero by itself
				next_count = inc[CNT_W-1:0];
			end
		end
	end

	// ****************************************
	// register file and bus
	// ****************************************
	always_comb begin
		next_ctrl0 = ctrl0;
		next_ctrl1 = timer_control_one;
		next_cmpa = compare_a_value;
		next_mask = mask;
		next_dat = 32'h0000_0000;
		if (wr) begin
			case (adr_i)
				OFF_CTRL0: next_ctrl0 = merge8(ctrl0, dat_i[7:0], sel_i[0]);
				OFF_CTRL1: next_ctrl1 = merge8(timer_control_one, dat_i[7:0],
					sel_i[0]);
				OFF_CMPA: begin
					next_cmpa[7:0] = merge8(compare_a_value[7:0], dat_i[7:0],
						sel_i[0]);
					if (sel_i[1]) begin
						next_cmpa[CNT_W-1:8] = dat_i[CNT_W-1:8];
					end
				end
				OFF_MASK: begin
					if (sel_i[0]) begin
						next_mask = dat_i[1:0];
					end
				end
				default: next_mask = mask;
			endcase
		end
		if (req && !we_i) begin
			case (adr_i)
				OFF_CTRL0: next_dat = {24'h000000, ctrl0};
				OFF_CTRL1: next_dat = {24'h000000, timer_control_one};
				OFF_CMPA: next_dat = {22'h000000, compare_a_value};
				OFF_COUNT: next_dat = {22'h000000, count};
				OFF_STATUS: next_dat = {30'h00000000, status};
				OFF_MASK: next_dat = {30'h00000000, mask};
				default: next_dat = 32'h0000_0000;
			endcase
		end
		next_ack = req;
		// a match in the read cycle survives the clear
		next_status = (status & ~{2{status_rd}}) | {p_event, a_event};
		next_irq = |(next_status & next_mask);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl0 <= CTRL0_RST;
			timer_control_one <= CTRL1_RST;
			compare_a_value <= CMPA_RST;
			count <= '0;
			status <= 2'h0;
			mask <= MASK_RST;
			on_q <= 1'b0;
			dat_o <= 32'h0000_0000;
			ack_o <= 1'b0;
			irq_o <= 1'b0;
		end else begin
			ctrl0 <= next_ctrl0;
			timer_control_one <= next_ctrl1;
			compare_a_value <= next_cmpa;
			count <= next_count;
			status <= next_status;
			mask <= next_mask;
			on_q <= counter_on;
			dat_o <= next_dat;
			ack_o <= next_ack;
			irq_o <= next_irq;
		end
	end

	// ****************************************
	// output pin
	// ****************************************
	assign pif.mode = mode;
	assign pif.out_func = timer_control_one[FUNC_HI:FUNC_LO];
	assign pif.level_ctl = timer_control_one[LEVEL_BIT];
	assign pif.invert = timer_control_one[INVERT_BIT];
	assign pif.start = start;
	assign pif.a_event = a_event;
	// duty compare uses whichever register does not set the period
	assign pif.duty_active = timer_control_one[SWAP_BIT] ?
		(count[CNT_W-1:CNT_W-PER_W] < period_compare_value)
		: (count < compare_a_value);

	timer_pin_stage u_pin (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ctl(pif),
		.pin_o(timer_out_pin_a_o),
		.oe_o(timer_pin_oe_o)
	);
	assign timer_out_pin_b_o = timer_out_pin_a_o;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_a_clear;
		running && !is_pwm && timer_control_one[CLRSEL_BIT] && a_hit;
	endsequence
	sequence s_p_clear;
		running && !is_pwm && !timer_control_one[CLRSEL_BIT] && p_hit;
	endsequence

	ack_single_a: assert property (ack_o |=> !ack_o)
		else $error("ack held longer than one cycle");
	clear_a_a: assert property (s_a_clear |=> count == '0)
		else $error("counter not cleared on A match");
	clear_p_a: assert property (s_p_clear |=> count == '0)
		else $error("counter not cleared on P match");
	no_p_flag_a: assert property (
		!is_pwm && timer_control_one[CLRSEL_BIT] |-> !p_event)
		else $error("P flag raised with A clearing");
	zero_a_a: assert property (compare_a_value == '0 |-> !a_event)
		else $error("A flag raised with zero compare");
	overflow_wrap_a: assert property (
		running && count == CNT_MAX |=> count == '0)
		else $error("counter did not wrap at top");
	period_step_a: assert property (
		p_hit |-> inc[CNT_W-PER_W-1:0] == '0)
		else $error("period match off a 128 step");
	flag_hold_a: assert property (
		a_event ##1 !status_rd [*2] |-> status[FLAG_A])
		else $error("A flag lost before read");
	irq_level_a: assert property (
		|(status & mask) |-> irq_o)
		else $error("irq low with unmasked flag");
endmodule

//--- dv/compact_timer_test.sv
`timescale 1ns/100ps
module compact_timer_test;
	import timer_pkg::*;
	// ****************************************
	// signals
	// ****************************************
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic we_i = 1'b0;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic count_tick_i = 1'b0;
	logic [7:0] adr_i = 8'h00;
	logic [31:0] dat_i = 32'h00000000;
	logic [3:0] sel_i = 4'hF;
	logic [31:0] dat_o;
	logic [31:0] q;
	logic ack_o;
	logic irq_o;
	logic pin_a;
	logic pin_b;
	logic oe;
	int mismatches = 0;
	int checks = 0;
	int cycles = 0;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_t;
	// write then read back; upper bits read 0, count is read only
	row_t rows[6] = '{'{OFF_CTRL1, 32'h000000A5, 32'h000000A5},
		'{OFF_CMPA, 32'hFFFFFFFF, 32'h000003FF},
		'{OFF_MASK, 32'hFFFFFFFF, 32'h00000003},
		'{OFF_COUNT, 32'h000003FF, 32'h00000000},
		'{8'h18, 32'hFFFFFFFF, 32'h00000000},
		'{OFF_CTRL0, 32'h000000F7, 32'h000000F7}};

	compact_timer dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i),
		.dat_i(dat_i), .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i),
		.cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
		.count_tick_i(count_tick_i), .irq_o(irq_o),
		.timer_out_pin_a_o(pin_a), .timer_out_pin_b_o(pin_b),
		.timer_pin_oe_o(oe));

	always #10 clk_i = ~clk_i;

	// ****************************************
	// tasks
	// ****************************************
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// hang guard: runs need about 2700 cycles
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			final_report();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// classic cycle, held until ack is seen at an edge
	task automatic wb(input logic [7:0] a, input logic [31:0] d,
		input logic w);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		adr_i <= a;
		dat_i <= d;
		we_i <= w;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic tick(input int n);
		count_tick_i <= 1'b1;
		repeat (n) @(posedge clk_i);
		count_tick_i <= 1'b0;
		@(posedge clk_i);
	endtask

	// counter_on low then high, so the pin takes its initial level
	task automatic start(input logic [7:0] c1, input logic [9:0] ca,
		input logic [2:0] per);
		wb(OFF_CTRL0, 32'h00000000, 1'b1);
		wb(OFF_CTRL1, {24'h000000, c1}, 1'b1);
		wb(OFF_CMPA, {22'h000000, ca}, 1'b1);
		wb(OFF_STATUS, 32'h00000000, 1'b0);
		wb(OFF_CTRL0, {28'h0000000, 1'b1, per}, 1'b1);
		@(posedge clk_i);
	endtask

	// ****************************************
	// sequence
	// ****************************************
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk({ack_o, irq_o, pin_a, pin_b, oe}, 5'h00);
		for (int i = 0; i < 6; i++) begin
			wb(8'(i * 4), 32'h00000000, 1'b0);
			chk(q, 32'h00000000);
		end
		foreach (rows[i]) begin
			wb(rows[i].a, rows[i].d, 1'b1);
			wb(rows[i].a, 32'h00000000, 1'b0);
			chk(q, rows[i].e);
		end
		// toggle on A, clear on P at 128, masked irq
		wb(OFF_MASK, 32'h00000000, 1'b1);
		start(8'h30, 10'h005, 3'h1);
		chk(pin_a, 1'b0);
		chk(oe, 1'b1);
		tick(5);
		chk({pin_a, pin_b}, 2'h3);
		wb(OFF_COUNT, 32'h00000000, 1'b0);
		chk(q, 32'h00000005);
		tick(123);
		wb(OFF_COUNT, 32'h00000000, 1'b0);
		chk(q, 32'h00000000);
		chk(pin_a, 1'b1);
		chk(irq_o, 1'b0);
		wb(OFF_MASK, 32'h00000003, 1'b1);
		@(posedge clk_i);
		chk(irq_o, 1'b1);
		wb(OFF_STATUS, 32'h00000000, 1'b0);
		chk(q, 32'h00000003);
		@(posedge clk_i);
		chk(irq_o, 1'b0);
		wb(OFF_STATUS, 32'h00000000, 1'b0);
		chk(q, 32'h00000000);
		// every pin action; initial level picked so each is visible
		for (int f = 0; f < 4; f++) begin
			start({2'b00, 2'(f), 4'b1011 >> f & 4'h1 ? 1'b1 : 1'b0,
				3'b000}, 10'h003, 3'h0);
			tick(3);
			chk(pin_a, 4'b0101 >> f & 4'h1 ? 1'b1 : 1'b0);
		end
		// A clearing: no P flag although period lies below A
		start(8'h19, 10'h0C8, 3'h1);
		chk(pin_a, 1'b1);
		tick(200);
		wb(OFF_COUNT, 32'h00000000, 1'b0);
		chk(q, 32'h00000000);
		chk(pin_a, 1'b0);
		wb(OFF_STATUS, 32'h00000000, 1'b0);
		chk(q, 32'h00000001);
		// overflow with both clear sources, no flags
		for (int c = 0; c < 2; c++) begin
			start(8'(c), 10'h000, 3'h0);
			tick(1023);
			wb(OFF_COUNT, 32'h00000000, 1'b0);
			chk(q, 32'h000003FF);
			tick(1);
			wb(OFF_COUNT, 32'h00000000, 1'b0);
			chk(q, 32'h00000000);
			wb(OFF_STATUS, 32'h00000000, 1'b0);
			chk(q, 32'h00000000);
		end
		start(8'h0C, 10'h000, 3'h1);
		chk(pin_a, 1'b0);
		// timer/counter mode: pin released, flags as usual
		start(8'hF0, 10'h003, 3'h0);
		chk(oe, 1'b0);
		tick(3);
		wb(OFF_STATUS, 32'h00000000, 1'b0);
		chk(q, 32'h00000001);
		// pwm, duty from A with swap 0, active high then low
		start(8'hA9, 10'h00A, 3'h1);
		tick(5);
		chk({pin_a, oe}, 2'h3);
		tick(10);
		chk(pin_a, 1'b0);
		wb(OFF_CTRL1, 32'h00000098, 1'b1);
		@(posedge clk_i);
		chk(pin_a, 1'b1);
		wb(OFF_CTRL1, 32'h000000A0, 1'b1);
		@(posedge clk_i);
		chk(pin_a, 1'b1);
		final_report();
	end
endmodule
